// >>> shared/objctl_pkg.sv
// Constants, modes and states for the switchgear object control block.
// Assumes a 25 MHz system clock; all timing counts derive from it.
package objctl_pkg;

  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned PULSE_MAX_MS    = 200;
  localparam int unsigned TERM_TIMEOUT_MS = 10_000;
  localparam int unsigned PULSE_CYC       = (CLK_HZ / 1000) * PULSE_MAX_MS;
  localparam int unsigned TERM_CYC        = (CLK_HZ / 1000) * TERM_TIMEOUT_MS;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned TMR_W           = 32;

  typedef enum logic [1:0] {
    OBJ_WD_BREAKER,
    OBJ_BREAKER,
    OBJ_MAIN_DISC,
    OBJ_EARTH_DISC
  } obj_type_t;

  typedef enum logic [1:0] {
    RDY_NOT_USED,
    RDY_HIGH,
    RDY_LOW
  } rdy_mode_t;

  typedef enum logic [1:0] {
    POS_INTERMEDIATE,
    POS_OPEN,
    POS_CLOSED,
    POS_BAD
  } pos_t;

  localparam logic [2:0] WD_INTERMEDIATE = 3'h0;
  localparam logic [2:0] WD_CART_OUT     = 3'h1;
  localparam logic [2:0] WD_CART_IN      = 3'h2;
  localparam logic [2:0] WD_BAD          = 3'h3;
  localparam logic [2:0] WD_NOT_IN_USE   = 3'h4;

  function automatic pos_t decode_pos(input logic open_i, input logic closed_i);
    unique case ({open_i, closed_i})
      2'b00: decode_pos = POS_INTERMEDIATE;
      2'b10: decode_pos = POS_OPEN;
      2'b01: decode_pos = POS_CLOSED;
      2'b11: decode_pos = POS_BAD;
    endcase
  endfunction : decode_pos

endpackage : objctl_pkg

// >>> hdl/req_counter.sv
// Saturating request counter with synchronous clear.
// Assumes one increment pulse per request.
module req_counter
  import objctl_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         inc_in,
  input  wire logic         clr_in,
  output      logic [W-1:0] count_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (clr_in) begin
      state_next.cnt = '0;
    end else if (inc_in && (state_reg.cnt != {W{1'b1}})) begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_out = state_reg.cnt;

endmodule : req_counter

// >>> hdl/close_gate.sv
// Combinational permission checks for open and close commands.
// Assumes all inputs are synchronous levels.
module close_gate
  import objctl_pkg::*;
(
  input  obj_type_t      obj_kind_in,
  input  wire logic      sync_use_in,
  input  wire logic      sync_sel_ext_in,
  input  wire logic      sync_int_in,
  input  wire logic      sync_ext_in,
  input  rdy_mode_t      rdy_mode_in,
  input  wire logic      ready_in,
  input  wire logic      open_ilock_in,
  input  wire logic      close_ilock_in,
  output      logic      sync_ok_out,
  output      logic      ready_ok_out,
  output      logic      open_allowed_out,
  output      logic      close_allowed_out
);

  logic checks_apply;
  logic sync_perm;

  always_comb begin
    checks_apply = (obj_kind_in == OBJ_WD_BREAKER) || (obj_kind_in == OBJ_BREAKER);
    sync_perm    = sync_sel_ext_in ? sync_ext_in : sync_int_in;
    sync_ok_out  = !checks_apply || !sync_use_in || sync_perm;
    unique case (rdy_mode_in)
      RDY_HIGH: ready_ok_out = !checks_apply || ready_in;
      RDY_LOW:  ready_ok_out = !checks_apply || !ready_in;
      default:  ready_ok_out = 1'b1;
    endcase
    open_allowed_out  = (obj_kind_in != OBJ_EARTH_DISC) && !(checks_apply && open_ilock_in);
    close_allowed_out = (obj_kind_in != OBJ_EARTH_DISC) && sync_ok_out && ready_ok_out
                        && !(checks_apply && close_ilock_in);
  end

endmodule : close_gate

// >>> hdl/object_control.sv
// Top of the switchgear object control: status decode, command sequencing, statistics.
// Assumes position and command inputs are synchronous to CLK_IN and debounced.
module object_control
  import objctl_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned TERM_CYCLES  = TERM_CYC
) (
  input  wire logic             CLK_IN,
  input  wire logic             RST_N_IN,
  input  obj_type_t             OBJ_TYPE_IN,
  input  wire logic             REMOTE_MODE_IN,
  input  wire logic             SYNC_USE_IN,
  input  wire logic             SYNC_SEL_EXT_IN,
  input  wire logic             SYNC_INT_IN,
  input  wire logic             SYNC_EXT_IN,
  input  rdy_mode_t             RDY_MODE_IN,
  input  wire logic             READY_IN,
  input  wire logic             OPEN_POS_IN,
  input  wire logic             CLOSED_POS_IN,
  input  wire logic             CART_INSERTED_INPUT_IN,
  input  wire logic             CART_REMOVED_INPUT_IN,
  input  wire logic             OPEN_ILOCK_IN,
  input  wire logic             CLOSE_ILOCK_IN,
  input  wire logic             LOCAL_OPEN_IN,
  input  wire logic             LOCAL_CLOSE_IN,
  input  wire logic             REMOTE_OPEN_IN,
  input  wire logic             REMOTE_CLOSE_IN,
  input  wire logic             APP_OPEN_IN,
  input  wire logic             APP_CLOSE_IN,
  input  wire logic             CLEAR_STATS_IN,
  output      logic             OPEN_CMD_OUT,
  output      logic             CLOSE_CMD_OUT,
  output      pos_t             BREAKER_STATUS_OUT,
  output      logic [2:0]       CART_STATUS_OUT,
  output      logic             OPEN_ALLOWED_OUT,
  output      logic             CLOSE_ALLOWED_OUT,
  output      logic             OBJ_READY_OUT,
  output      logic             SYNC_OK_OUT,
  output      logic             CLEAR_BUSY_OUT,
  output      logic             TIMEOUT_ERR_OUT,
  output      logic [CNT_W-1:0] OPEN_OK_CNT_OUT,
  output      logic [CNT_W-1:0] CLOSE_OK_CNT_OUT,
  output      logic [CNT_W-1:0] OPEN_FAIL_CNT_OUT,
  output      logic [CNT_W-1:0] CLOSE_FAIL_CNT_OUT
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE,
    ST_WAIT
  } seq_t;

  typedef struct packed {
    seq_t             seq;
    logic             is_close;
    logic [TMR_W-1:0] pulse_tmr;
    logic [TMR_W-1:0] term_tmr;
    logic             open_cmd;
    logic             close_cmd;
    pos_t             pos;
    logic [2:0]       cart;
    logic             open_allowed;
    logic             close_allowed;
    logic             ready_ok;
    logic             sync_ok;
    logic             clr_busy;
    logic             clr_seen;
    logic             tout_err;
    logic             inc_open_ok;
    logic             inc_close_ok;
    logic             inc_open_fail;
    logic             inc_close_fail;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic sync_ok;
  logic ready_ok;
  logic open_allowed;
  logic close_allowed;
  logic open_req;
  logic close_req;
  logic target_reached;
  pos_t pos_now;

  close_gate u_gate (
    .obj_kind_in       (OBJ_TYPE_IN),
    .sync_use_in       (SYNC_USE_IN),
    .sync_sel_ext_in   (SYNC_SEL_EXT_IN),
    .sync_int_in       (SYNC_INT_IN),
    .sync_ext_in       (SYNC_EXT_IN),
    .rdy_mode_in       (RDY_MODE_IN),
    .ready_in          (READY_IN),
    .open_ilock_in     (OPEN_ILOCK_IN),
    .close_ilock_in    (CLOSE_ILOCK_IN),
    .sync_ok_out       (sync_ok),
    .ready_ok_out      (ready_ok),
    .open_allowed_out  (open_allowed),
    .close_allowed_out (close_allowed)
  );

  always_comb begin
    pos_now = decode_pos(OPEN_POS_IN, CLOSED_POS_IN);
    // Local/remote selection of command sources
    open_req  = APP_OPEN_IN || (REMOTE_MODE_IN ? REMOTE_OPEN_IN : LOCAL_OPEN_IN);
    close_req = APP_CLOSE_IN || (REMOTE_MODE_IN ? REMOTE_CLOSE_IN : LOCAL_CLOSE_IN);
    target_reached = state_reg.is_close ? (pos_now == POS_CLOSED) : (pos_now == POS_OPEN);
  end

  always_comb begin
    state_next                = state_reg;
    state_next.pos            = pos_now;
    state_next.open_allowed   = open_allowed;
    state_next.close_allowed  = close_allowed;
    state_next.ready_ok       = ready_ok;
    state_next.sync_ok        = sync_ok;
    state_next.inc_open_ok    = 1'b0;
    state_next.inc_close_ok   = 1'b0;
    state_next.inc_open_fail  = 1'b0;
    state_next.inc_close_fail = 1'b0;
    state_next.tout_err       = 1'b0;

    if (OBJ_TYPE_IN == OBJ_WD_BREAKER) begin
      unique case ({CART_INSERTED_INPUT_IN, CART_REMOVED_INPUT_IN})
        2'b00: state_next.cart = WD_INTERMEDIATE;
        2'b01: state_next.cart = WD_CART_OUT;
        2'b10: state_next.cart = WD_CART_IN;
        2'b11: state_next.cart = WD_BAD;
      endcase
    end else begin
      state_next.cart = WD_NOT_IN_USE;
    end

    // Clear takes one cycle, then busy stays low until the request is released and raised again
    state_next.clr_busy = 1'b0;
    if (CLEAR_STATS_IN && !state_reg.clr_seen) begin
      state_next.clr_busy = 1'b1;
      state_next.clr_seen = 1'b1;
    end else if (!CLEAR_STATS_IN) begin
      state_next.clr_seen = 1'b0;
    end

    unique case (state_reg.seq)
      ST_IDLE: begin
        state_next.pulse_tmr = '0;
        state_next.term_tmr  = '0;
        if (open_req) begin
          if (open_allowed) begin
            state_next.seq      = ST_PULSE;
            state_next.is_close = 1'b0;
            state_next.open_cmd = 1'b1;
          end else begin
            state_next.inc_open_fail = 1'b1;
          end
        end else if (close_req) begin
          if (close_allowed) begin
            state_next.seq       = ST_PULSE;
            state_next.is_close  = 1'b1;
            state_next.close_cmd = 1'b1;
          end else begin
            state_next.inc_close_fail = 1'b1;
          end
        end
      end
      ST_PULSE, ST_WAIT: begin
        state_next.pulse_tmr = state_reg.pulse_tmr + 1'b1;
        state_next.term_tmr  = state_reg.term_tmr + 1'b1;
        if (state_reg.pulse_tmr >= PULSE_CYCLES - 1) begin
          state_next.open_cmd  = 1'b0;
          state_next.close_cmd = 1'b0;
          state_next.seq       = ST_WAIT;
        end
        if (target_reached) begin
          state_next.open_cmd     = 1'b0;
          state_next.close_cmd    = 1'b0;
          state_next.seq          = ST_IDLE;
          state_next.inc_open_ok  = !state_reg.is_close;
          state_next.inc_close_ok = state_reg.is_close;
        end else if (state_reg.term_tmr >= TERM_CYCLES - 1) begin
          state_next.open_cmd       = 1'b0;
          state_next.close_cmd      = 1'b0;
          state_next.seq            = ST_IDLE;
          state_next.tout_err       = 1'b1;
          state_next.inc_open_fail  = !state_reg.is_close;
          state_next.inc_close_fail = state_reg.is_close;
        end
      end
      default: begin
        state_next.seq = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg      <= '0;
      state_reg.cart <= WD_NOT_IN_USE;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [3:0]       inc_vec;
  logic [CNT_W-1:0] cnt_arr [4];

  assign inc_vec = {state_reg.inc_close_fail, state_reg.inc_open_fail,
                    state_reg.inc_close_ok, state_reg.inc_open_ok};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      req_counter #(
        .W (CNT_W)
      ) u_cnt (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .inc_in    (inc_vec[gi]),
        .clr_in    (state_reg.clr_busy),
        .count_out (cnt_arr[gi])
      );
    end
  endgenerate

  assign OPEN_CMD_OUT       = state_reg.open_cmd;
  assign CLOSE_CMD_OUT      = state_reg.close_cmd;
  assign BREAKER_STATUS_OUT = state_reg.pos;
  assign CART_STATUS_OUT    = state_reg.cart;
  assign OPEN_ALLOWED_OUT   = state_reg.open_allowed;
  assign CLOSE_ALLOWED_OUT  = state_reg.close_allowed;
  assign OBJ_READY_OUT      = state_reg.ready_ok;
  assign SYNC_OK_OUT        = state_reg.sync_ok;
  assign CLEAR_BUSY_OUT     = state_reg.clr_busy;
  assign TIMEOUT_ERR_OUT    = state_reg.tout_err;
  assign OPEN_OK_CNT_OUT    = cnt_arr[0];
  assign CLOSE_OK_CNT_OUT   = cnt_arr[1];
  assign OPEN_FAIL_CNT_OUT  = cnt_arr[2];
  assign CLOSE_FAIL_CNT_OUT = cnt_arr[3];

endmodule : object_control

// >>> verif/objctl_asserts.sv
// Concurrent checks on the object control top-level ports.
// Assumes binding into object_control with its timing parameters.
module objctl_asserts
  import objctl_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 20,
  parameter int unsigned TERM_CYCLES  = 100
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input obj_type_t OBJ_TYPE_IN,
  input wire logic SYNC_USE_IN,
  input wire logic SYNC_SEL_EXT_IN,
  input wire logic SYNC_INT_IN,
  input wire logic SYNC_EXT_IN,
  input rdy_mode_t RDY_MODE_IN,
  input wire logic READY_IN,
  input wire logic OPEN_POS_IN,
  input wire logic CLOSED_POS_IN,
  input wire logic CLEAR_STATS_IN,
  input wire logic OPEN_CMD_OUT,
  input wire logic CLOSE_CMD_OUT,
  input pos_t      BREAKER_STATUS_OUT,
  input wire logic CLEAR_BUSY_OUT,
  input wire logic TIMEOUT_ERR_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic        brk;
  logic        perm;
  logic        rdy_ok;
  int unsigned plen;
  assign brk = (OBJ_TYPE_IN == OBJ_WD_BREAKER) || (OBJ_TYPE_IN == OBJ_BREAKER);
  assign perm = SYNC_SEL_EXT_IN ? SYNC_EXT_IN : SYNC_INT_IN;
  assign rdy_ok = (RDY_MODE_IN == RDY_HIGH) ? READY_IN : !(RDY_MODE_IN == RDY_LOW && READY_IN);
  // Length of the current command pulse
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) plen <= 0;
    else plen <= (OPEN_CMD_OUT || CLOSE_CMD_OUT) ? plen + 1 : 0;
  end
  property p_sync; $rose(CLOSE_CMD_OUT) && brk |-> $past(perm) || !$past(SYNC_USE_IN); endproperty
  property p_rdy; $rose(CLOSE_CMD_OUT) && brk |-> $past(rdy_ok); endproperty
  property p_earth; OBJ_TYPE_IN == OBJ_EARTH_DISC |-> !OPEN_CMD_OUT && !CLOSE_CMD_OUT; endproperty
  property p_excl; !(OPEN_CMD_OUT && CLOSE_CMD_OUT); endproperty
  property p_plen; plen <= PULSE_CYCLES; endproperty
  property p_early;
    (OPEN_CMD_OUT && OPEN_POS_IN) || (CLOSE_CMD_OUT && CLOSED_POS_IN)
      |-> ##[1:2] !(OPEN_CMD_OUT || CLOSE_CMD_OUT);
  endproperty
  property p_stat;
    $past(RST_N_IN) |-> BREAKER_STATUS_OUT == pos_t'({$past(CLOSED_POS_IN), $past(OPEN_POS_IN)});
  endproperty
  property p_clr; $rose(CLEAR_STATS_IN) |=> CLEAR_BUSY_OUT ##1 !CLEAR_BUSY_OUT; endproperty
  property p_terr; TIMEOUT_ERR_OUT |=> !TIMEOUT_ERR_OUT; endproperty
  a_sync: assert property (p_sync) else $error("close without sync permission");
  a_rdy: assert property (p_rdy) else $error("close while not ready");
  a_earth: assert property (p_earth) else $error("earthing switch commanded");
  a_excl: assert property (p_excl) else $error("open and close together");
  a_plen: assert property (p_plen) else $error("command pulse too long");
  a_early: assert property (p_early) else $error("pulse kept after target");
  a_stat: assert property (p_stat) else $error("breaker status decode");
  a_clr: assert property (p_clr) else $error("clear busy not one pulse");
  a_terr: assert property (p_terr) else $error("timeout error not a pulse");
  c_open: cover property ($rose(OPEN_CMD_OUT));
  c_close: cover property ($rose(CLOSE_CMD_OUT) && brk);
  c_tout: cover property (TIMEOUT_ERR_OUT);
endmodule : objctl_asserts

bind object_control objctl_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .TERM_CYCLES(TERM_CYCLES)) u_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .OBJ_TYPE_IN(OBJ_TYPE_IN), .SYNC_USE_IN(SYNC_USE_IN),
  .SYNC_SEL_EXT_IN(SYNC_SEL_EXT_IN), .SYNC_INT_IN(SYNC_INT_IN), .SYNC_EXT_IN(SYNC_EXT_IN),
  .RDY_MODE_IN(RDY_MODE_IN), .READY_IN(READY_IN), .OPEN_POS_IN(OPEN_POS_IN),
  .CLOSED_POS_IN(CLOSED_POS_IN), .CLEAR_STATS_IN(CLEAR_STATS_IN), .OPEN_CMD_OUT(OPEN_CMD_OUT),
  .CLOSE_CMD_OUT(CLOSE_CMD_OUT), .BREAKER_STATUS_OUT(BREAKER_STATUS_OUT),
  .CLEAR_BUSY_OUT(CLEAR_BUSY_OUT), .TIMEOUT_ERR_OUT(TIMEOUT_ERR_OUT));

// >>> verif/breaker_model.sv
// Behavioural breaker whose auxiliary contacts follow the command pulses.
// Assumes commands are levels on the system clock; stuck holds the contacts.
module breaker_model (
  input  wire logic       clk_in,
  input  wire logic       open_cmd_in,
  input  wire logic       close_cmd_in,
  input  wire logic       stuck_in,
  input  wire logic [3:0] dly_in,
  output      logic       open_pos_out,
  output      logic       closed_pos_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    open_pos_out = 1'h1;
    closed_pos_out = 1'h0;
  end
  // Contacts leave the end position, then settle after the travel delay
  always @(posedge clk_in) begin
    if (stuck_in || !(open_cmd_in || close_cmd_in)) cnt <= 0;
    else begin
      cnt <= cnt + 1;
      if (cnt == 0) {open_pos_out, closed_pos_out} <= 2'h0;
      if (cnt == dly_in) begin
        open_pos_out <= open_cmd_in;
        closed_pos_out <= close_cmd_in;
      end
    end
  end
endmodule : breaker_model

// >>> verif/tb.sv
// Self-checking bench for object_control driving a behavioural breaker.
// Assumes shortened pulse and termination counts set through parameters.
module tb
  import objctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0;
  obj_type_t ot = OBJ_BREAKER;
  rdy_mode_t rm = RDY_NOT_USED;
  logic remote = 1'h1, su = 1'h0, sx = 1'h0, si = 1'h0, se = 1'h0, rdy = 1'h0;
  logic oil = 1'h0, cil = 1'h0, cin = 1'h1, cout = 1'h0, clr = 1'h0, stuck = 1'h0;
  logic [5:0] rq = '0;
  logic [3:0] dly = 4'h1;
  logic opos, cpos, ocmd, ccmd, terr, oal, cal, rdyo, synco;
  logic [2:0] cst;
  logic [31:0] c0, c1, c2, c3;
  logic [127:0] cnts_q = '0;
  logic [31:0] e [4] = '{default: '0};
  logic [127:0] exp_q [$];
  int err_total = 0, num_checks = 0, cyc = 0, terr_n = 0;
  always #20 clk = ~clk;
  object_control #(.PULSE_CYCLES(20), .TERM_CYCLES(100)) dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .OBJ_TYPE_IN(ot), .REMOTE_MODE_IN(remote),
    .SYNC_USE_IN(su), .SYNC_SEL_EXT_IN(sx), .SYNC_INT_IN(si), .SYNC_EXT_IN(se),
    .RDY_MODE_IN(rm), .READY_IN(rdy), .OPEN_POS_IN(opos), .CLOSED_POS_IN(cpos),
    .CART_INSERTED_INPUT_IN(cin), .CART_REMOVED_INPUT_IN(cout), .OPEN_ILOCK_IN(oil),
    .CLOSE_ILOCK_IN(cil), .LOCAL_OPEN_IN(rq[0]), .LOCAL_CLOSE_IN(rq[1]),
    .REMOTE_OPEN_IN(rq[2]), .REMOTE_CLOSE_IN(rq[3]), .APP_OPEN_IN(rq[4]),
    .APP_CLOSE_IN(rq[5]), .CLEAR_STATS_IN(clr), .OPEN_CMD_OUT(ocmd), .CLOSE_CMD_OUT(ccmd),
    .BREAKER_STATUS_OUT(), .CART_STATUS_OUT(cst), .OPEN_ALLOWED_OUT(oal),
    .CLOSE_ALLOWED_OUT(cal), .OBJ_READY_OUT(rdyo), .SYNC_OK_OUT(synco), .CLEAR_BUSY_OUT(),
    .TIMEOUT_ERR_OUT(terr), .OPEN_OK_CNT_OUT(c0), .CLOSE_OK_CNT_OUT(c1),
    .OPEN_FAIL_CNT_OUT(c2), .CLOSE_FAIL_CNT_OUT(c3));
  breaker_model u_brk (.clk_in(clk), .open_cmd_in(ocmd), .close_cmd_in(ccmd),
    .stuck_in(stuck), .dly_in(dly), .open_pos_out(opos), .closed_pos_out(cpos));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (err_total == 0 && num_checks > 0 && exp_q.size() == 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Any counter change takes the oldest expected note
  always @(posedge clk) begin
    cyc++;
    if (terr === 1'h1) terr_n++;
    cnts_q <= {c0, c1, c2, c3};
    if (rst_n && {c0, c1, c2, c3} !== cnts_q) begin
      if (exp_q.size() == 0) check({c0, c1, c2, c3}, '1, "unexpected count");
      else check({c0, c1, c2, c3}, exp_q.pop_front(), "counters");
    end
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  function automatic logic brk();
    return ot == OBJ_WD_BREAKER || ot == OBJ_BREAKER;
  endfunction : brk
  function automatic logic ook();
    return ot != OBJ_EARTH_DISC && !(brk() && oil);
  endfunction : ook
  function automatic logic cok();
    return ot != OBJ_EARTH_DISC && !(brk() && (cil || (su && !(sx ? se : si))
           || (rm == RDY_HIGH && !rdy) || (rm == RDY_LOW && rdy)));
  endfunction : cok
  // Request the opposite position from one source: 0 local, 1 remote, 2 app
  task automatic req(input int src);
    logic cl;
    logic ign;
    int n;
    cl = opos;
    ign = (src == 0 && remote) || (src == 1 && !remote);
    if (!ign) begin
      n = (stuck || !(cl ? cok() : ook())) ? 2 + cl : cl;
      e[n] = e[n] + 1;
      exp_q.push_back({e[0], e[1], e[2], e[3]});
    end
    rq[2 * src + cl] <= 1'h1;
    @(posedge clk) rq <= '0;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
  endtask : req
  task automatic rnd(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      ot <= obj_type_t'($urandom_range(3));
      rm <= rdy_mode_t'($urandom_range(2));
      {remote, su, sx, si, se, rdy, oil, cil} <= 8'($urandom);
      dly <= 4'($urandom_range(8, 1));
      repeat (3) @(posedge clk);
      check(oal, ook(), "open allowed");
      check(cal, cok(), "close allowed");
      check(rdyo, !brk() || (rm == RDY_HIGH ? rdy : !(rm == RDY_LOW && rdy)), "ready");
      check(synco, !brk() || !su || (sx ? se : si), "sync ok");
      req($urandom_range(2));
    end
  endtask : rnd
  initial begin
    void'($urandom(67));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      ot <= OBJ_WD_BREAKER;
      {cin, cout} <= 2'(c);
      repeat (3) @(posedge clk);
      check(cst, 3'(c), "cart status");
    end
    ot <= OBJ_BREAKER;
    {cin, cout} <= 2'h2;
    repeat (3) @(posedge clk);
    check(cst, WD_NOT_IN_USE, "cart status");
    rnd(20);
    su <= 1'h0;
    rm <= RDY_NOT_USED;
    {oil, cil} <= 2'h0;
    ot <= OBJ_BREAKER;
    stuck <= 1'h1;
    @(posedge clk);
    req(2);
    check(terr_n, 1, "timeout pulses");
    stuck <= 1'h0;
    e = '{default: '0};
    exp_q.push_back('0);
    clr <= 1'h1;
    @(posedge clk) clr <= 1'h0;
    repeat (5) @(posedge clk);
    rnd(20);
    summarize();
  end
endmodule : tb
